// [common/acs_pkg.sv]
// Purpose: Shared constants and carriers for the accel bias-trim and
//          auto-sleep block.
// Assumes: Register offsets are the device's byte addresses.
// Notes:   Sample scale is full-resolution counts of one quarter trim count.
package acs_pkg;

   // Register offsets
   localparam logic [7:0] ADDR_X_TRIM = 8'h1E;
   localparam logic [7:0] ADDR_Y_TRIM = 8'h1F;
   localparam logic [7:0] ADDR_Z_TRIM = 8'h20;
   localparam logic [7:0] ADDR_MOTION_STATUS = 8'h2B;
   localparam logic [7:0] ADDR_CAUSE = 8'h30;
   localparam logic [7:0] ADDR_X_LO = 8'h32;
   localparam logic [7:0] ADDR_X_HI = 8'h33;
   localparam logic [7:0] ADDR_Y_LO = 8'h34;
   localparam logic [7:0] ADDR_Y_HI = 8'h35;
   localparam logic [7:0] ADDR_Z_LO = 8'h36;
   localparam logic [7:0] ADDR_Z_HI = 8'h37;

   // Reset values and field positions
   localparam logic [7:0] TRIM_RESET = 8'h00;
   localparam int STATUS_ASLEEP_BIT = 3;
   localparam int CAUSE_READY_BIT = 7;
   localparam int CAUSE_ACT_BIT = 4;
   localparam int CAUSE_INACT_BIT = 3;

   // Format and rate constants
   localparam int TRIM_ALIGN = 2;
   localparam int FIXED_BITS = 10;
   localparam logic [3:0] RATE_MAX = 4'hF;
   localparam logic [3:0] SLEEP_RATE = 4'h3;
   localparam int DEC_W = 15;

   typedef struct packed {
      logic signed [12:0] x;
      logic signed [12:0] y;
      logic signed [12:0] z;
   } acs_raw_t;

   typedef struct packed {
      logic signed [15:0] x;
      logic signed [15:0] y;
      logic signed [15:0] z;
   } acs_axes_t;

   typedef struct packed {
      logic [3:0] rate;
      logic [1:0] range;
      logic full_res;
      logic low_power;
      logic link;
      logic auto_sleep;
      logic sleep_en;
      logic improved_tap;
   } acs_cfg_t;

   typedef enum logic {
      LNK_WAIT_INACT,
      LNK_WAIT_ACT
   } acs_link_t;

endpackage : acs_pkg

// [rtl/acs_top.sv]
// Purpose: Output path with per-axis bias trim plus linked auto-sleep.
// Assumes: Raw samples arrive at the shared base rate; detectors are
//          outside and report hits on the feeds this block provides.
// Notes:   Register port is a simple internal read/write strobe port.
`timescale 1ns/1ps
module acs_top (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata_q,
   // Configuration
   input wire acs_pkg::acs_cfg_t cfg,
   // Raw sample stream
   input wire logic raw_valid,
   input wire acs_pkg::acs_raw_t raw,
   // Detector hits
   input wire logic act_hit,
   input wire logic inact_hit,
   input wire logic tap_hit,
   input wire logic [2:0] tap_axis,
   // Detector feeds
   output logic motion_feed_valid_q,
   output acs_pkg::acs_axes_t motion_feed_q,
   output logic tap_feed_valid_q,
   output acs_pkg::acs_axes_t tap_feed_q,
   output logic act_arm_q,
   output logic inact_arm_q,
   // Output data and status
   output logic out_stb_q,
   output acs_pkg::acs_axes_t out_q,
   output logic asleep_q,
   output logic act_irq_q,
   output logic inact_irq_q,
   output logic ready_irq_q
);

   // Trim, add and saturate one axis; trim weight ignores range only in full resolution
   function automatic logic signed [15:0] trim_axis(
      input logic signed [12:0] s,
      input logic [7:0] t,
      input logic full_res,
      input logic [1:0] range);
      logic signed [16:0] sum;
      logic signed [16:0] lim;
      int bits;
      sum = 17'(s) + (17'(signed'(t)) <<< acs_pkg::TRIM_ALIGN);
      bits = full_res ? acs_pkg::FIXED_BITS + int'(range)
                      : acs_pkg::FIXED_BITS;
      if (!full_res) begin
         sum = sum >>> range;
      end
      lim = 17'((32'sd1 <<< (bits - 1)) - 1);
      if (sum > lim) begin
         sum = lim;
      end else if (sum < -lim - 17'sd1) begin
         sum = -lim - 17'sd1;
      end
      return sum[15:0];
   endfunction : trim_axis

   // Widen raw samples for the detector feeds
   function automatic acs_pkg::acs_axes_t widen(input acs_pkg::acs_raw_t r);
      widen.x = 16'(r.x);
      widen.y = 16'(r.y);
      widen.z = 16'(r.z);
   endfunction : widen

   logic [7:0] trim_q [3];
   logic [acs_pkg::DEC_W-1:0] dec_cnt_q;
   logic [acs_pkg::DEC_W-1:0] dec_lim;
   logic [3:0] eff_rate;
   logic dec_hit;
   acs_pkg::acs_link_t state_q;
   acs_pkg::acs_link_t state_d;
   logic act_evt;
   logic inact_evt;
   logic sleep_go;
   logic cause_rd;
   logic [2:0] tap_src_q;
   acs_pkg::acs_axes_t prev_out_q;

   // trim registers
   // Trims only change on host writes; the sum uses them live
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         for (int i = 0; i < 3; i++) begin
            trim_q[i] <= acs_pkg::TRIM_RESET;
         end
      end else if (reg_wr) begin
         if (reg_addr == acs_pkg::ADDR_X_TRIM) trim_q[0] <= reg_wdata;
         if (reg_addr == acs_pkg::ADDR_Y_TRIM) trim_q[1] <= reg_wdata;
         if (reg_addr == acs_pkg::ADDR_Z_TRIM) trim_q[2] <= reg_wdata;
      end
   end

   // sleep rate select
   // Sleep swaps the divider only; the base stream never stops
   assign eff_rate = asleep_q ? acs_pkg::SLEEP_RATE : cfg.rate;
   assign dec_lim = acs_pkg::DEC_W'((16'd1 << (acs_pkg::RATE_MAX - eff_rate))
                    - 16'd1);
   assign dec_hit = raw_valid && (dec_cnt_q >= dec_lim);

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         dec_cnt_q <= '0;
      end else if (raw_valid) begin
         dec_cnt_q <= dec_hit ? '0 : dec_cnt_q + 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         out_q <= '0;
         prev_out_q <= '0;
         out_stb_q <= 1'b0;
      end else begin
         out_stb_q <= dec_hit;
         if (dec_hit) begin
            out_q.x <= trim_axis(raw.x, trim_q[0], cfg.full_res, cfg.range);
            out_q.y <= trim_axis(raw.y, trim_q[1], cfg.full_res, cfg.range);
            out_q.z <= trim_axis(raw.z, trim_q[2], cfg.full_res, cfg.range);
            prev_out_q <= out_q;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         motion_feed_q <= '0;
         motion_feed_valid_q <= 1'b0;
      end else begin
         motion_feed_valid_q <= raw_valid;
         if (raw_valid) begin
            motion_feed_q <= widen(raw);
         end
      end
   end

   // improved tap feed
   // Differences of consecutive outputs strip the static gravity term
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         tap_feed_q <= '0;
         tap_feed_valid_q <= 1'b0;
      end else if (cfg.improved_tap) begin
         tap_feed_valid_q <= out_stb_q;
         if (out_stb_q) begin
            tap_feed_q.x <= out_q.x - prev_out_q.x;
            tap_feed_q.y <= out_q.y - prev_out_q.y;
            tap_feed_q.z <= out_q.z - prev_out_q.z;
         end
      end else begin
         tap_feed_valid_q <= raw_valid;
         if (raw_valid) begin
            tap_feed_q <= widen(raw);
         end
      end
   end

   // Link sequencing
   assign act_evt = act_hit && act_arm_q;
   assign inact_evt = inact_hit && inact_arm_q;
   assign sleep_go = cfg.link && cfg.auto_sleep && cfg.sleep_en &&
                     inact_evt && !act_irq_q;

   always_comb begin
      state_d = state_q;
      if (!cfg.link) begin
         state_d = acs_pkg::LNK_WAIT_INACT;
      end else begin
         unique case (state_q)
            acs_pkg::LNK_WAIT_INACT: begin
               if (inact_evt) state_d = acs_pkg::LNK_WAIT_ACT;
            end
            acs_pkg::LNK_WAIT_ACT: begin
               if (act_evt) state_d = acs_pkg::LNK_WAIT_INACT;
            end
         endcase
      end
   end

   // Arming follows the next state so outputs stay registered
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         state_q <= acs_pkg::LNK_WAIT_INACT;
         act_arm_q <= 1'b1;
         inact_arm_q <= 1'b1;
      end else begin
         state_q <= state_d;
         act_arm_q <= !cfg.link || state_d == acs_pkg::LNK_WAIT_ACT;
         inact_arm_q <= !cfg.link || state_d == acs_pkg::LNK_WAIT_INACT;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         asleep_q <= 1'b0;
      end else if (asleep_q && (act_evt || !cfg.link)) begin
         asleep_q <= 1'b0;
      end else if (sleep_go) begin
         asleep_q <= 1'b1;
      end
   end

   // ready kept in low power
   // A new event in the clearing cycle wins over the read
   assign cause_rd = reg_rd && reg_addr == acs_pkg::ADDR_CAUSE;

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         act_irq_q <= 1'b0;
         inact_irq_q <= 1'b0;
         ready_irq_q <= 1'b0;
      end else begin
         act_irq_q <= act_evt || (act_irq_q && !cause_rd);
         inact_irq_q <= inact_evt || (inact_irq_q && !cause_rd);
         ready_irq_q <= dec_hit || (ready_irq_q &&
                        !(reg_rd && reg_addr == acs_pkg::ADDR_X_LO));
      end
   end

   // Tap axis is overwritten on each tap, so it holds the latest; only reset clears it
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         tap_src_q <= '0;
      end else if (tap_hit) begin
         tap_src_q <= tap_axis;
      end
   end

   // asleep in status
   // Read data is registered; unmapped offsets return zero
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         reg_rdata_q <= '0;
      end else if (reg_rd) begin
         unique case (reg_addr)
            acs_pkg::ADDR_X_TRIM: reg_rdata_q <= trim_q[0];
            acs_pkg::ADDR_Y_TRIM: reg_rdata_q <= trim_q[1];
            acs_pkg::ADDR_Z_TRIM: reg_rdata_q <= trim_q[2];
            acs_pkg::ADDR_MOTION_STATUS: begin
               reg_rdata_q <= {4'h0, asleep_q, tap_src_q};
            end
            acs_pkg::ADDR_CAUSE: begin
               reg_rdata_q <= {ready_irq_q, 2'b00, act_irq_q,
                               inact_irq_q, 3'b000};
            end
            acs_pkg::ADDR_X_LO: reg_rdata_q <= out_q.x[7:0];
            acs_pkg::ADDR_X_HI: reg_rdata_q <= out_q.x[15:8];
            acs_pkg::ADDR_Y_LO: reg_rdata_q <= out_q.y[7:0];
            acs_pkg::ADDR_Y_HI: reg_rdata_q <= out_q.y[15:8];
            acs_pkg::ADDR_Z_LO: reg_rdata_q <= out_q.z[7:0];
            acs_pkg::ADDR_Z_HI: reg_rdata_q <= out_q.z[15:8];
            default: reg_rdata_q <= '0;
         endcase
      end
   end

   // Checks
   sequence s_sleep_entry;
      cfg.link && cfg.auto_sleep && cfg.sleep_en &&
      state_q == acs_pkg::LNK_WAIT_INACT && inact_evt && !act_irq_q &&
      !asleep_q;
   endsequence

   // Link must still be set, or the arms fall back to both armed
   sequence s_wake;
      asleep_q && act_evt && cfg.link;
   endsequence

   property p_trim_reset;
      @(posedge clk) !rst_b |=> trim_q[0] == acs_pkg::TRIM_RESET &&
         trim_q[1] == acs_pkg::TRIM_RESET && trim_q[2] == acs_pkg::TRIM_RESET;
   endproperty
   a_trim_reset: assert property (p_trim_reset)
      else $error("trim not zero after reset");

   property p_read_clear;
      @(posedge clk) disable iff (!rst_b)
         cause_rd && !act_hit && !inact_hit |=> !act_irq_q && !inact_irq_q;
   endproperty
   a_read_clear: assert property (p_read_clear)
      else $error("cause read did not clear flags");

   property p_no_sleep_pending;
      @(posedge clk) disable iff (!rst_b)
         !asleep_q && act_irq_q |=> !asleep_q;
   endproperty
   a_no_sleep_pending: assert property (p_no_sleep_pending)
      else $error("slept with activity pending");

   property p_status_asleep;
      @(posedge clk) disable iff (!rst_b)
         reg_rd && reg_addr == acs_pkg::ADDR_MOTION_STATUS |=>
         reg_rdata_q[acs_pkg::STATUS_ASLEEP_BIT] == $past(asleep_q);
   endproperty
   a_status_asleep: assert property (p_status_asleep)
      else $error("status asleep bit wrong");

   property p_sleep_entry;
      @(posedge clk) disable iff (!rst_b)
         s_sleep_entry |=> asleep_q && act_arm_q && !inact_arm_q;
   endproperty
   a_sleep_entry: assert property (p_sleep_entry)
      else $error("inactivity did not enter sleep");

   property p_wake;
      @(posedge clk) disable iff (!rst_b)
         s_wake |=> !asleep_q && act_irq_q && inact_arm_q && !act_arm_q;
   endproperty
   a_wake: assert property (p_wake)
      else $error("activity did not wake and rearm");

   property p_link_arm;
      @(posedge clk) disable iff (!rst_b)
         cfg.link && $past(cfg.link) |-> act_arm_q != inact_arm_q;
   endproperty
   a_link_arm: assert property (p_link_arm)
      else $error("linked mode armed both detectors");

   property p_decim;
      @(posedge clk) disable iff (!rst_b)
         out_stb_q |-> $past(raw_valid) && ready_irq_q;
   endproperty
   a_decim: assert property (p_decim)
      else $error("output without base sample");

   property p_zero_trim;
      @(posedge clk) disable iff (!rst_b)
         dec_hit && cfg.full_res && cfg.range == 2'b11 && trim_q[0] == 8'h00
         |=> out_q.x == 16'($past(raw.x));
   endproperty
   a_zero_trim: assert property (p_zero_trim)
      else $error("zero trim changed the sample");

   property p_low_power_ready;
      @(posedge clk) disable iff (!rst_b)
         cfg.low_power && dec_hit |=> out_stb_q && ready_irq_q;
   endproperty
   a_low_power_ready: assert property (p_low_power_ready)
      else $error("low power lost the data ready flag");

endmodule : acs_top

// [bench/acs_host.sv]
// Purpose: Host model on the register strobe port of the bias-trim block.
// Assumes: Strobes launch just after a rising edge, one access per call.
// Notes:   Read data is taken 1 ns after the edge that samples the strobe.
`timescale 1ns/1ps
module acs_host (
   // Clock
   input wire logic clk,
   // Register port
   output logic [7:0] reg_addr,
   output logic reg_wr,
   output logic reg_rd,
   output logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata_q
);
   // Strobes idle from time zero so nothing is taken during reset
   initial begin
      reg_addr = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = 8'h00;
   end

   // Write; data is scrambled on release so a late capture shows up
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_wdata <= ~d;
   endtask : wr

   // Read; result is settled just after the taking edge
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata_q;
   endtask : rd

   task automatic service(output logic [7:0] d);
      rd(acs_pkg::ADDR_CAUSE, d);
   endtask : service

   function automatic logic [7:0] trim_for(input int e);
      int t;
      t = (e >= 0) ? -((e + 2) / 4) : ((2 - e) / 4);
      return t[7:0];
   endfunction : trim_for
endmodule : acs_host

// [bench/test_accel_offset_and_autosleep.sv]
// Purpose: Self-checking bench for the bias-trim and auto-sleep block.
// Assumes: Host model owns the register port; bench drives the rest.
// Notes:   Rate code 15 passes every sample, so trims show at once.
`timescale 1ns/1ps
module test_accel_offset_and_autosleep;
   logic clk;
   logic rst_b;
   logic [7:0] reg_addr;
   logic reg_wr;
   logic reg_rd;
   logic [7:0] reg_wdata;
   logic [7:0] reg_rdata_q;
   acs_pkg::acs_cfg_t cfg;
   logic raw_valid;
   acs_pkg::acs_raw_t raw;
   logic act_hit;
   logic inact_hit;
   logic tap_hit;
   logic [2:0] tap_axis;
   logic motion_feed_valid_q;
   acs_pkg::acs_axes_t motion_feed_q;
   logic tap_feed_valid_q;
   acs_pkg::acs_axes_t tap_feed_q;
   logic act_arm_q;
   logic inact_arm_q;
   logic out_stb_q;
   acs_pkg::acs_axes_t out_q;
   logic asleep_q;
   logic act_irq_q;
   logic inact_irq_q;
   logic ready_irq_q;
   int bad_count = 0;
   int check_count = 0;

   acs_top acs_top_i (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
      .reg_rdata_q(reg_rdata_q), .cfg(cfg), .raw_valid(raw_valid),
      .raw(raw), .act_hit(act_hit), .inact_hit(inact_hit),
      .tap_hit(tap_hit), .tap_axis(tap_axis),
      .motion_feed_valid_q(motion_feed_valid_q),
      .motion_feed_q(motion_feed_q), .tap_feed_valid_q(tap_feed_valid_q),
      .tap_feed_q(tap_feed_q), .act_arm_q(act_arm_q),
      .inact_arm_q(inact_arm_q), .out_stb_q(out_stb_q), .out_q(out_q),
      .asleep_q(asleep_q), .act_irq_q(act_irq_q),
      .inact_irq_q(inact_irq_q), .ready_irq_q(ready_irq_q));

   acs_host acs_host_i (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q));

   // 100 MHz clock
   initial clk = 1'b0;
   always #5 clk = ~clk;

   // Flag comparison
   task automatic chk_bit(input string n, input logic e, input logic g);
      check_count++;
      if (g !== e) begin
         bad_count++;
         $display("unexpected %s expected %b seen %b", n, e, g);
      end
   endtask : chk_bit

   // Value comparison; bytes arrive zero-extended
   task automatic chk_val(input string n, input logic [15:0] e,
      input logic [15:0] g);
      check_count++;
      if (g !== e) begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask : chk_val

   // Low power goes with unlinked runs so data-ready is seen there
   task automatic set_cfg(input logic [3:0] r, input logic [1:0] g,
      input logic f, input logic l);
      @(posedge clk);
      cfg <= '{rate: r, range: g, full_res: f, low_power: ~l, link: l,
         auto_sleep: l, sleep_en: l, improved_tap: 1'b0};
      @(posedge clk);
   endtask : set_cfg

   // One base-rate sample, outputs looked at after the taking edge
   task automatic sample(input int x, input int y, input int z);
      @(posedge clk);
      raw <= {x[12:0], y[12:0], z[12:0]};
      raw_valid <= 1'b1;
      @(posedge clk);
      raw_valid <= 1'b0;
      #1;
   endtask : sample

   // One detector pulse
   task automatic hit(input logic a, input logic i);
      @(posedge clk);
      act_hit <= a;
      inact_hit <= i;
      @(posedge clk);
      act_hit <= 1'b0;
      inact_hit <= 1'b0;
      #1;
   endtask : hit

   task automatic t_reset;
      logic [7:0] d;
      for (int a = 8'h1E; a <= 8'h20; a++) begin
         acs_host_i.rd(a[7:0], d);
         chk_val("trim reset", 16'h0000, {8'h00, d});
      end
      chk_bit("act arm", 1'b1, act_arm_q);
      chk_bit("asleep", 1'b0, asleep_q);
   endtask : t_reset

   task automatic t_trim;
      logic [7:0] d;
      set_cfg(4'hF, 2'd3, 1'b1, 1'b0);
      sample(10, -13, 9);
      chk_val("x untrimmed", 16'h000A, out_q.x);
      acs_host_i.wr(acs_pkg::ADDR_X_TRIM, acs_host_i.trim_for(10));
      acs_host_i.wr(acs_pkg::ADDR_Y_TRIM, acs_host_i.trim_for(-13));
      acs_host_i.wr(acs_pkg::ADDR_Z_TRIM, acs_host_i.trim_for(9));
      acs_host_i.rd(acs_pkg::ADDR_X_TRIM, d);
      chk_val("x trim", 16'h00FD, {8'h00, d});
      sample(10, -13, 9);
      chk_bit("strobe", 1'b1, out_stb_q);
      chk_val("x out", 16'hFFFE, out_q.x);
      chk_val("y out", 16'hFFFF, out_q.y);
      chk_val("z out", 16'h0001, out_q.z);
      acs_host_i.rd(acs_pkg::ADDR_CAUSE, d);
      chk_bit("ready", 1'b1, d[7]);
      acs_host_i.rd(acs_pkg::ADDR_X_LO, d);
      chk_val("x low", 16'h00FE, {8'h00, d});
      chk_bit("ready clr", 1'b0, ready_irq_q);
      acs_host_i.rd(acs_pkg::ADDR_X_HI, d);
      chk_val("x high", 16'h00FF, {8'h00, d});
   endtask : t_trim

   task automatic t_format;
      set_cfg(4'hF, 2'd0, 1'b1, 1'b0);
      acs_host_i.wr(acs_pkg::ADDR_X_TRIM, 8'h7F);
      acs_host_i.wr(acs_pkg::ADDR_Z_TRIM, 8'h80);
      sample(511, 0, -512);
      chk_val("x clamp", 16'h01FF, out_q.x);
      chk_val("y range", 16'h000C, out_q.y);
      chk_val("z clamp", 16'hFE00, out_q.z);
      set_cfg(4'hF, 2'd1, 1'b0, 1'b0);
      acs_host_i.wr(acs_pkg::ADDR_X_TRIM, 8'h01);
      sample(100, 0, 0);
      chk_val("x fixed", 16'h0034, out_q.x);
   endtask : t_format

   // Rate code 13 keeps one sample in four
   task automatic t_decim;
      int n_out;
      int n_raw;
      n_out = 0;
      n_raw = 0;
      set_cfg(4'hD, 2'd3, 1'b1, 1'b0);
      for (int i = 0; i <= 8; i++) begin
         @(posedge clk);
         raw_valid <= (i < 8);
         #1;
         if (i > 0) begin
            n_out += out_stb_q;
            n_raw += motion_feed_valid_q;
         end
      end
      chk_val("strobes", 16'd2, n_out[15:0]);
      chk_val("feeds", 16'd8, n_raw[15:0]);
      set_cfg(4'hF, 2'd3, 1'b1, 1'b0);
   endtask : t_decim

   // Plain feeds carry raw samples; improved tap sees output steps
   task automatic t_feed;
      sample(40, 0, 0);
      chk_val("motion feed", 16'h0028, motion_feed_q.x);
      chk_val("plain tap feed", 16'h0028, tap_feed_q.x);
      @(posedge clk);
      cfg.improved_tap <= 1'b1;
      sample(56, 0, 0);
      chk_bit("tap early", 1'b0, tap_feed_valid_q);
      @(posedge clk);
      #1;
      chk_bit("tap valid", 1'b1, tap_feed_valid_q);
      chk_val("tap step", 16'h0010, tap_feed_q.x);
   endtask : t_feed

   task automatic t_tap;
      logic [7:0] d;
      @(posedge clk);
      tap_hit <= 1'b1;
      tap_axis <= 3'b101;
      @(posedge clk);
      tap_hit <= 1'b0;
      tap_axis <= 3'b010;
      acs_host_i.rd(acs_pkg::ADDR_MOTION_STATUS, d);
      chk_val("status", 16'h0005, {8'h00, d});
   endtask : t_tap

   task automatic t_link;
      logic [7:0] d;
      set_cfg(4'hF, 2'd3, 1'b1, 1'b1);
      hit(1'b0, 1'b1);
      chk_bit("inact irq", 1'b1, inact_irq_q);
      chk_bit("asleep", 1'b1, asleep_q);
      chk_bit("act arm", 1'b1, act_arm_q);
      chk_bit("inact arm", 1'b0, inact_arm_q);
      acs_host_i.rd(acs_pkg::ADDR_MOTION_STATUS, d);
      chk_val("status", 16'h000D, {8'h00, d});
      acs_host_i.service(d);
      chk_bit("cause inact", 1'b1, d[3]);
      acs_host_i.service(d);
      chk_bit("cause cleared", 1'b0, d[3]);
      hit(1'b0, 1'b1);
      chk_bit("inact ignored", 1'b0, inact_irq_q);
      sample(1, 1, 1);
      chk_bit("slow strobe", 1'b0, out_stb_q);
      hit(1'b1, 1'b0);
      chk_bit("act irq", 1'b1, act_irq_q);
      chk_bit("awake", 1'b0, asleep_q);
      chk_bit("act arm", 1'b0, act_arm_q);
      chk_bit("inact arm", 1'b1, inact_arm_q);
      sample(1, 1, 1);
      chk_bit("rate back", 1'b1, out_stb_q);
   endtask : t_link

   // Activity flag left pending on purpose
   task automatic t_blocked;
      logic [7:0] d;
      hit(1'b0, 1'b1);
      chk_bit("no sleep", 1'b0, asleep_q);
      chk_bit("act arm", 1'b1, act_arm_q);
      acs_host_i.service(d);
      chk_bit("cause act", 1'b1, d[4]);
      chk_bit("act clr", 1'b0, act_irq_q);
      acs_host_i.rd(8'h00, d);
      chk_val("unmapped", 16'h0000, {8'h00, d});
      acs_host_i.wr(acs_pkg::ADDR_MOTION_STATUS, 8'hFF);
      acs_host_i.rd(acs_pkg::ADDR_MOTION_STATUS, d);
      chk_val("status ro", 16'h0005, {8'h00, d});
   endtask : t_blocked

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : report_and_stop

   // Whole run needs well under a thousand cycles
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      $display("unexpected watchdog expected done seen hang");
      report_and_stop;
   end

   // Main sequence
   initial begin
      rst_b = 1'b0;
      cfg = '0;
      raw_valid = 1'b0;
      raw = '0;
      act_hit = 1'b0;
      inact_hit = 1'b0;
      tap_hit = 1'b0;
      tap_axis = 3'b000;
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      t_reset;
      t_trim;
      t_format;
      t_decim;
      t_feed;
      t_tap;
      t_link;
      t_blocked;
      report_and_stop;
   end
endmodule : test_accel_offset_and_autosleep
